// ===== design/pcoe_pin_sync.sv
`timescale 1ns/1ps

// ****************************************************************
// Control pin synchroniser with rising edge detect
// ****************************************************************
module pcoe_pin_sync (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;
  logic rise_q, rise_d;

  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
    prev_d = sync_q;
    rise_d = sync_q & ~prev_q;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
      rise_q <= rise_d;
    end
  end

  // Level is delayed to line up with the registered edge pulse
  assign level_o = prev_q;
  assign rise_o  = rise_q;

endmodule

// ===== design/pcoe_top.sv
`timescale 1ns/1ps
`include "pcoe_consts.svh"

// How it works
// [R1] An output in its on state is driven high, tied to the common supply.
// [R2] An output in its off state is pulled low to ground by its low-side switch.
// [R3] Every rising edge of the control pin advances a counter decoded into 32 or 64 states.
// [R4] Output k is off when bit k-1 of the pulse count minus one is set, otherwise on.
// [R5] After the last pulse the host holds the pin high and the count is latched and applied.
// [R6] The first rising edge after disable enables the device with every output on.
// [R7] The five-channel build uses five outputs and 32 counts; the six-channel build all 64.
// [R8] The count is latched once the pin has been high for the 500 us latch timeout.
// [R9] After the pin has been low for the 500 us off timeout all outputs go low and it disables.
// [R10] The host may pulse at up to 1 MHz so intermediate counts never show, or pulse slowly.
// [R11] Within a sequence the host keeps every high phase below 75 us.
// [R12] Disabling clears the counter so the next rising edge starts again at state one.
module pcoe_top
  import pcoe_pkg::*;
#(
  parameter logic         SIX_CHANNEL  = 1'b1,
  parameter pcoe_tmr_type LATCH_CYCLES =
    `PCOE_TMR_W'(`PCOE_LATCH_TIMEOUT_NS / `PCOE_CLK_PERIOD_NS),
  parameter pcoe_tmr_type OFF_CYCLES   =
    `PCOE_TMR_W'(`PCOE_OFF_TIMEOUT_NS / `PCOE_CLK_PERIOD_NS)
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ctrl_pin_i,
  output logic      enabled_o,
  output logic      switch_output_1_o,
  output logic      switch_output_2_o,
  output logic      switch_output_3_o,
  output logic      switch_output_4_o,
  output logic      switch_output_5_o,
  output logic      switch_output_6_o
);

  // ****************************************************************
  // Pin input
  // ****************************************************************
  logic pin_level;
  logic pin_rise;

  pcoe_pin_sync u_pin_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (ctrl_pin_i),
    .level_o (pin_level),
    .rise_o  (pin_rise)
  );

  // ****************************************************************
  // Control state
  // ****************************************************************
  pcoe_state_type state_q, state_d;
  pcoe_ctl_type   ctl_q, ctl_d;
  logic           latch_evt;
  logic           off_evt;

  always_comb begin
    latch_evt = (state_q == PCOE_ST_ON) && pin_level && !pin_rise &&
                (ctl_q.hi_cnt == LATCH_CYCLES - `PCOE_TMR_W'(1)); // [R8]
    off_evt   = (state_q == PCOE_ST_ON) && !pin_level &&
                (ctl_q.lo_cnt == OFF_CYCLES - `PCOE_TMR_W'(1)); // [R9]
  end

  always_comb begin
    state_d = state_q;
    ctl_d   = ctl_q;
    // High phase timer restarts on every edge; saturates so one latch per phase
    if (!pin_level) begin
      ctl_d.hi_cnt = '0;
    end else if (pin_rise) begin
      ctl_d.hi_cnt = `PCOE_TMR_W'(1);
    end else if (ctl_q.hi_cnt != LATCH_CYCLES) begin
      ctl_d.hi_cnt = ctl_q.hi_cnt + `PCOE_TMR_W'(1);
    end
    if (pin_level || state_q == PCOE_ST_OFF) begin
      ctl_d.lo_cnt = '0;
    end else if (ctl_q.lo_cnt != OFF_CYCLES) begin
      ctl_d.lo_cnt = ctl_q.lo_cnt + `PCOE_TMR_W'(1);
    end
    unique case (state_q)
      PCOE_ST_OFF: begin
        if (pin_rise) begin
          state_d   = PCOE_ST_ON;
          ctl_d.cnt = `PCOE_CNT_FIRST;
          ctl_d.out = pcoe_decode(`PCOE_CNT_FIRST, SIX_CHANNEL); // [R6]
        end
      end
      PCOE_ST_ON: begin
        if (pin_rise) begin
          // Outputs hold while pulses arrive; only a latch shows a new count
          ctl_d.cnt = (ctl_q.cnt + `PCOE_CNT_STEP) & pcoe_mask(SIX_CHANNEL); // [R3] [R7]
        end else if (latch_evt) begin
          ctl_d.out = pcoe_decode(ctl_q.cnt, SIX_CHANNEL); // [R4] [R5]
        end else if (off_evt) begin
          state_d   = PCOE_ST_OFF;
          ctl_d.out = `PCOE_ALL_OFF; // [R2] [R9]
          ctl_d.cnt = `PCOE_CNT_FIRST; // [R12]
        end
      end
    endcase
    ctl_d.en = (state_d == PCOE_ST_ON);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= PCOE_ST_OFF;
      ctl_q   <= '0;
    end else begin
      state_q <= state_d;
      ctl_q   <= ctl_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // A one drives the pad from the supply, a zero turns on the pull-down
  assign enabled_o         = ctl_q.en;
  assign switch_output_1_o = ctl_q.out[0]; // [R1] [R2]
  assign switch_output_2_o = ctl_q.out[1];
  assign switch_output_3_o = ctl_q.out[2];
  assign switch_output_4_o = ctl_q.out[3];
  assign switch_output_5_o = ctl_q.out[4];
  assign switch_output_6_o = ctl_q.out[5];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking chk_clk @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  pcoe_pat_type all_on;
  assign all_on = pcoe_decode(`PCOE_CNT_FIRST, SIX_CHANNEL);

  outputs_need_enable_a: assert property ( // [R1]
    (ctl_q.out != `PCOE_ALL_OFF) |-> ctl_q.en)
    else $error("output high while disabled");

  disabled_all_low_a: assert property ( // [R2]
    !ctl_q.en |-> (ctl_q.out == `PCOE_ALL_OFF) && (ctl_q.cnt == `PCOE_CNT_FIRST))
    else $error("disabled device has an output high or a stale count");

  count_advance_a: assert property ( // [R3]
    (state_q == PCOE_ST_ON) && pin_rise |=>
      ctl_q.cnt == ((($past(ctl_q.cnt)) + `PCOE_CNT_STEP) & pcoe_mask(SIX_CHANNEL)))
    else $error("counter did not advance on a rising edge");

  latch_applies_a: assert property ( // [R4]
    latch_evt |=> ctl_q.out == pcoe_decode($past(ctl_q.cnt), SIX_CHANNEL) ##1
      ctl_q.out == $past(ctl_q.out))
    else $error("latched pattern does not match the count");

  hold_high_latch_a: assert property ( // [R5]
    (state_q == PCOE_ST_ON) && pin_rise ##1 pin_level [*2] |->
      ctl_q.out == $past(ctl_q.out, 2))
    else $error("outputs changed before the latch timeout");

  first_edge_on_a: assert property ( // [R6]
    (state_q == PCOE_ST_OFF) && pin_rise |=> ctl_q.en && (ctl_q.out == all_on))
    else $error("first edge did not switch every output on");

  five_channel_a: assert property ( // [R7]
    !SIX_CHANNEL |-> !ctl_q.out[5] && !ctl_q.cnt[5])
    else $error("sixth output used on the five-channel build");

  latch_timing_a: assert property ( // [R8]
    ctl_q.en && $past(ctl_q.en) && (ctl_q.out != $past(ctl_q.out)) |->
      $past(ctl_q.hi_cnt) == LATCH_CYCLES - `PCOE_TMR_W'(1))
    else $error("pattern changed without a full latch timeout");

  off_timing_a: assert property ( // [R9]
    $fell(ctl_q.en) |-> $past(ctl_q.lo_cnt) == OFF_CYCLES - `PCOE_TMR_W'(1))
    else $error("disabled before the off timeout");

  // A rise just after the timeout may legally re-enable at once
  off_clears_a: assert property ( // [R12]
    off_evt |=> !ctl_q.en && (ctl_q.cnt == `PCOE_CNT_FIRST) ##1
      (ctl_q.en == $past(pin_rise)))
    else $error("disable did not clear the counter");

  enable_seen_c: cover property ((state_q == PCOE_ST_OFF) && pin_rise);
  last_state_c:  cover property (latch_evt && (ctl_q.cnt == pcoe_mask(SIX_CHANNEL)));
  relatch_c:     cover property (latch_evt && (ctl_q.cnt != `PCOE_CNT_FIRST));
  off_seen_c:    cover property (off_evt);

endmodule

// ===== shared/pcoe_consts.svh
`ifndef PCOE_CONSTS_SVH
`define PCOE_CONSTS_SVH

// ****************************************************************
// Clock and timeouts
// ****************************************************************
`define PCOE_CLK_PERIOD_NS      10
`define PCOE_LATCH_TIMEOUT_NS   500000
`define PCOE_OFF_TIMEOUT_NS     500000
`define PCOE_TMR_W              17

// ****************************************************************
// Counter and output patterns
// ****************************************************************
`define PCOE_CNT_W              6
`define PCOE_CNT_FIRST          6'h00
`define PCOE_CNT_STEP           6'h01
`define PCOE_MASK_SIX           6'h3f
`define PCOE_MASK_FIVE          6'h1f
`define PCOE_ALL_OFF            6'h00

`endif

// ===== shared/pcoe_pkg.sv
`include "pcoe_consts.svh"

package pcoe_pkg;

  typedef enum logic [1:0] {
    PCOE_ST_OFF = 2'b01,
    PCOE_ST_ON  = 2'b10
  } pcoe_state_type;

  typedef logic [`PCOE_CNT_W-1:0] pcoe_pat_type;
  typedef logic [`PCOE_TMR_W-1:0] pcoe_tmr_type;

  typedef struct packed {
    logic         en;
    pcoe_pat_type cnt;
    pcoe_pat_type out;
    pcoe_tmr_type hi_cnt;
    pcoe_tmr_type lo_cnt;
  } pcoe_ctl_type;

  // Count value is pulse number minus one; a set bit switches that output off
  function automatic pcoe_pat_type pcoe_decode(input pcoe_pat_type cnt, input logic six);
    return ~cnt & (six ? `PCOE_MASK_SIX : `PCOE_MASK_FIVE);
  endfunction

  function automatic pcoe_pat_type pcoe_mask(input logic six);
    return six ? `PCOE_MASK_SIX : `PCOE_MASK_FIVE;
  endfunction

endpackage

// ===== tb/pcoe_host_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Host GPIO driving the control pin
// ****************************************************************
module pcoe_host_model (
  input  wire logic clock_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;

  // Two-cycle high and three-cycle low phases: fast enough to hide intermediate counts, far below the latch span
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock_i) pin_o = 1'b1;
      repeat (2) @(negedge clock_i);
      if (i < n - 1) begin
        pin_o = 1'b0;
        repeat (2) @(negedge clock_i);
      end
    end
    pin_o = 1'b1;
  endtask

  task automatic idle(input int cyc);
    @(negedge clock_i) pin_o = 1'b0;
    repeat (cyc) @(negedge clock_i);
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps

// ****************************************************************
// Bench top
// ****************************************************************
module tb_top;
  import pcoe_pkg::*;
  // Short timeouts keep the run brief; the latch and disable waits below derive from them
  localparam pcoe_tmr_type LAT = 17'h00014;
  localparam pcoe_tmr_type OFF = 17'h0001e;
  logic              clock_i;
  logic              rst_i;
  wire logic         pin;
  wire logic         en6;
  wire logic         en5;
  wire pcoe_pat_type o6;
  wire pcoe_pat_type o5;
  int                error_cnt = 0;
  int                cmp_count = 0;
  int                counts[6] = '{1, 2, 3, 33, 64, 65};

  pcoe_host_model pcoe_host_model_i (.clock_i(clock_i), .pin_o(pin));

  pcoe_top #(.SIX_CHANNEL(1'b1), .LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcoe_top_i (
    .clock_i(clock_i), .rst_i(rst_i), .ctrl_pin_i(pin), .enabled_o(en6),
    .switch_output_1_o(o6[0]), .switch_output_2_o(o6[1]), .switch_output_3_o(o6[2]),
    .switch_output_4_o(o6[3]), .switch_output_5_o(o6[4]), .switch_output_6_o(o6[5])
  );

  // Five-channel build shares the pin so both decodes are judged on one sequence
  pcoe_top #(.SIX_CHANNEL(1'b0), .LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) pcoe_top_5_i (
    .clock_i(clock_i), .rst_i(rst_i), .ctrl_pin_i(pin), .enabled_o(en5),
    .switch_output_1_o(o5[0]), .switch_output_2_o(o5[1]), .switch_output_3_o(o5[2]),
    .switch_output_4_o(o5[3]), .switch_output_5_o(o5[4]), .switch_output_6_o(o5[5])
  );

  task automatic check(input pcoe_pat_type seen, input pcoe_pat_type exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic expect_off(input string msg);
    check({5'h00, en6}, 6'h00, msg);
    check(o6, 6'h00, msg);
    check({5'h00, en5}, 6'h00, msg);
    check(o5, 6'h00, msg);
  endtask

  task automatic test_reset();
    expect_off("after reset");
    $display("Reset test done");
  endtask

  task automatic test_count(input int n);
    pcoe_pat_type cnt;
    cnt = 6'(n - 1);
    pcoe_host_model_i.burst(n);
    repeat (6) @(negedge clock_i);
    check({5'h00, en6}, 6'h01, "enable");
    check({5'h00, en5}, 6'h01, "five enable");
    check(o6, 6'h3f, "six before latch");
    check(o5, 6'h1f, "five before latch");
    repeat (LAT + 8) @(negedge clock_i);
    check(o6, ~cnt, "six latched");
    check(o6, ~cnt & 6'h3f, "six count states");
    check(o5, ~cnt & 6'h1f, "five latched");
    check({5'h00, en6}, 6'h01, "still enabled");
    pcoe_host_model_i.idle(OFF + 10);
    expect_off("disable");
    $display("Test with %0d pulses done", n);
  endtask

  // A second burst after a latch keeps counting from the latched count
  task automatic test_relatch();
    pcoe_host_model_i.burst(3);
    repeat (LAT + 8) @(negedge clock_i);
    check(o6, ~6'h02, "first latch");
    check(o5, ~6'h02 & 6'h1f, "five first latch");
    pcoe_host_model_i.idle(2);
    pcoe_host_model_i.burst(2);
    repeat (6) @(negedge clock_i);
    check(o6, ~6'h02, "no intermediate count");
    repeat (LAT + 8) @(negedge clock_i);
    check(o6, ~6'h04, "second latch");
    check(o5, ~6'h04 & 6'h1f, "five second latch");
    pcoe_host_model_i.idle(OFF + 10);
    expect_off("relatch disable");
    $display("Relatch test done");
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    rst_i = 1'b1;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    test_reset();
    foreach (counts[i]) begin
      test_count(counts[i]);
    end
    test_relatch();
    end_of_test();
  end

  // All tests need about 1400 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    end_of_test();
  end
endmodule
